// ==== dbec_cfg.svh ====
`ifndef DBEC_CFG_SVH
`define DBEC_CFG_SVH

// Register offsets as seen on the host register port
`define DBEC_ADDR_CFG 20'hffe00
`define DBEC_ADDR_SCR_LO 20'hffe40
`define DBEC_ADDR_SCR_HI 20'hffe42
`define DBEC_ADDR_BUSERR 20'hffe52
`define DBEC_ADDR_LOCKCTL 20'hffe7a
`define DBEC_ADDR_PXADDR 20'hffe7c
`define DBEC_ADDR_IRQSTS 20'hffe80
`define DBEC_ADDR_IRQMASK 20'hffe82

// Virtual register window
`define DBEC_CORE_BASE 20'hffe00
`define DBEC_VIRT_FIRST 20'h01000
`define DBEC_VIRT_LAST 20'h01060
`define DBEC_WIN_FIRST 16'hd000
`define DBEC_WIN_LAST 16'hd060

// Field positions
`define DBEC_BIT_CORE_EN 0
`define DBEC_BIT_DBG_CLK 3
`define DBEC_BIT_LOCK 15
`define DBEC_BIT_INVAL 14
`define DBEC_BIT_PAUSE 1
`define DBEC_BIT_CLEAR 0
`define DBEC_PMEM_MSB 30
`define DBEC_PMEM_LSB 16
`define DBEC_IRQ_LOCK 0
`define DBEC_IRQ_INVAL 1
`define DBEC_IRQ_WDOG 2

// Reset values
`define DBEC_RST_SCRATCH 16'h0000
`define DBEC_RST_BUSERR 24'h000000
`define DBEC_RST_PMEM 15'h0000
`define DBEC_RST_XMEM 16'h0000
`define DBEC_RST_IRQ 3'h0

`endif

// ==== dbec_pkg.sv ====
package dbec_pkg;

  // Register selected by an address decode
  typedef enum logic [3:0] {
    SEL_NONE = 4'h0,
    SEL_CFG = 4'h1,
    SEL_SCR_LO = 4'h2,
    SEL_SCR_HI = 4'h3,
    SEL_BUSERR = 4'h4,
    SEL_LOCKCTL = 4'h5,
    SEL_PXADDR = 4'h6,
    SEL_IRQSTS = 4'h7,
    SEL_IRQMASK = 4'h8
  } dbec_sel_t;

  // Core execution state as seen by the pause logic
  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_HALT = 1'b1
  } dbec_run_t;

endpackage

// ==== dbec_debug_capture.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dbec_cfg.svh"

// What this block does
// - Four 16-bit scratch fields, two per word
// - Pass debug clock only while enable bit set
// - Locked write sets sticky lock flag
// - Undefined access sets sticky address flag
// - Writing one to clear bit clears both
// - First lock error captures program, data addresses
// - Program address is the prefetched one
// - Bus address frozen at first lock error
// - Otherwise bus address tracks latest invalid access
// - Bus address meaningless with both flags clear
// - Bus address recorded byte-referenced, twice register
// - Window access error records address zero
// - Pause bit halts core on lock error
// - Resume by clearing pause or cycling enable
// - Window decodes onto core registers, firmware only
// - Window sits at 0xD000 in data map
// - Bus error event on lock, invalid, watchdog
module dbec_debug_capture (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // Host register port
  input wire logic [19:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  // Core data bus, one request per cycle
  input wire logic dsp_req_in,
  input wire logic dsp_we_in,
  input wire logic [15:0] dsp_xaddr_in,
  input wire logic [31:0] dsp_wdata_in,
  input wire logic [22:0] dsp_reg_addr_in,
  input wire logic [14:0] dsp_pc_prefetch_in,
  input wire logic dsp_locked_in,
  input wire logic dsp_invalid_in,
  output logic [31:0] dsp_rdata_out,
  // Core control
  input wire logic watchdog_timeout_in,
  output logic dsp_halt_out,
  output logic core_enable_out,
  // Debug clock pin and gated copy
  input wire logic jtag_clock_in,
  output logic jtag_clock_core_out,
  // Events
  output logic bus_error_event_out,
  output logic irq_out
);

  // Register state
  logic dbg_en_q;
  logic core_en_q;
  logic [15:0] scratch_q [4];
  logic lock_q;
  logic inval_q;
  logic pause_q;
  logic [14:0] pmem_q;
  logic [15:0] xmem_q;
  logic [23:0] buserr_q;
  logic [2:0] irq_sts_q;
  logic [2:0] irq_mask_q;
  dbec_pkg::dbec_run_t run_q;
  dbec_pkg::dbec_run_t run_d;
  logic halt_q;
  logic [31:0] host_rdata_q;
  logic [31:0] dsp_rdata_q;
  logic jtag_meta_q;
  logic jtag_sync_q;
  logic jtag_gated_q;
  logic event_q;
  logic irq_q;

  // Address decode shared by both access paths
  function automatic dbec_pkg::dbec_sel_t decode(input logic [19:0] addr);
    dbec_pkg::dbec_sel_t sel;
    sel = dbec_pkg::SEL_NONE;
    unique case (addr)
      `DBEC_ADDR_CFG: sel = dbec_pkg::SEL_CFG;
      `DBEC_ADDR_SCR_LO: sel = dbec_pkg::SEL_SCR_LO;
      `DBEC_ADDR_SCR_HI: sel = dbec_pkg::SEL_SCR_HI;
      `DBEC_ADDR_BUSERR: sel = dbec_pkg::SEL_BUSERR;
      `DBEC_ADDR_LOCKCTL: sel = dbec_pkg::SEL_LOCKCTL;
      `DBEC_ADDR_PXADDR: sel = dbec_pkg::SEL_PXADDR;
      `DBEC_ADDR_IRQSTS: sel = dbec_pkg::SEL_IRQSTS;
      `DBEC_ADDR_IRQMASK: sel = dbec_pkg::SEL_IRQMASK;
      default: sel = dbec_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction

  // Read view of every register; unmapped reads as zero
  function automatic logic [31:0] read_word(input dbec_pkg::dbec_sel_t sel);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (sel)
      dbec_pkg::SEL_CFG: begin
        w[`DBEC_BIT_DBG_CLK] = dbg_en_q;
        w[`DBEC_BIT_CORE_EN] = core_en_q;
      end
      dbec_pkg::SEL_SCR_LO: w = {scratch_q[1], scratch_q[0]};
      dbec_pkg::SEL_SCR_HI: w = {scratch_q[3], scratch_q[2]};
      dbec_pkg::SEL_BUSERR: w = {8'h00, buserr_q};
      dbec_pkg::SEL_LOCKCTL: begin
        // Clear bit is a command and always reads zero
        w[`DBEC_BIT_LOCK] = lock_q;
        w[`DBEC_BIT_INVAL] = inval_q;
        w[`DBEC_BIT_PAUSE] = pause_q;
      end
      dbec_pkg::SEL_PXADDR: w = {1'b0, pmem_q, xmem_q};
      dbec_pkg::SEL_IRQSTS: w = {29'h0000_0000, irq_sts_q};
      dbec_pkg::SEL_IRQMASK: w = {29'h0000_0000, irq_mask_q};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Host side decode; the virtual range is not decoded here at all
  wire dbec_pkg::dbec_sel_t host_sel = decode(reg_addr_in);

  // Window hit in the core data map, firmware path only
  wire win_hit = dsp_req_in && (dsp_xaddr_in >= `DBEC_WIN_FIRST)
                 && (dsp_xaddr_in <= `DBEC_WIN_LAST);
  // Window offset lands on the matching core control register
  wire [19:0] win_reg_addr = `DBEC_CORE_BASE + {13'h0000, dsp_xaddr_in[6:0]};
  wire dbec_pkg::dbec_sel_t win_sel = decode(win_reg_addr);
  // Window offset with no register behind it
  wire win_bad = win_hit && (win_sel == dbec_pkg::SEL_NONE);
  wire win_wr = win_hit && dsp_we_in && !win_bad;

  // Single write port; a host write wins a same-cycle window write
  wire dbec_pkg::dbec_sel_t wr_sel = reg_write_in ? host_sel
                                   : (win_wr ? win_sel : dbec_pkg::SEL_NONE);
  wire [31:0] wr_data = reg_write_in ? reg_wdata_in : dsp_wdata_in;
  wire wr_cfg = (wr_sel == dbec_pkg::SEL_CFG);
  wire wr_lockctl = (wr_sel == dbec_pkg::SEL_LOCKCTL);
  wire wr_irqsts = (wr_sel == dbec_pkg::SEL_IRQSTS);
  wire wr_irqmask = (wr_sel == dbec_pkg::SEL_IRQMASK);

  // Error detection on the core bus
  wire lock_ev = dsp_req_in && dsp_we_in && dsp_locked_in && !win_hit;
  wire addr_ev = (dsp_req_in && dsp_invalid_in && !win_hit) || win_bad;
  wire clear_cmd = wr_lockctl && wr_data[`DBEC_BIT_CLEAR];
  // First lock capture stays frozen until cleared; a clear in the same
  // cycle as a new lock error lets the new one in
  wire lock_keep = lock_q && !clear_cmd;
  // Byte-referenced: register address shifted up by one, zero for window
  wire [23:0] fault_addr = win_bad ? 24'h000000 : {dsp_reg_addr_in, 1'b0};
  wire take_lock = lock_ev && !lock_keep;
  wire take_inval = addr_ev && !lock_ev && !lock_keep;
  wire [2:0] irq_set = {watchdog_timeout_in, addr_ev, lock_ev};

  // Scratch fields, one per 16-bit half of the two words
  for (genvar i = 0; i < 4; i++) begin : g_scratch
    localparam dbec_pkg::dbec_sel_t MY_SEL = (i < 2) ? dbec_pkg::SEL_SCR_LO
                                                      : dbec_pkg::SEL_SCR_HI;
    // Plain storage, no side effects from either master
    always_ff @(posedge clock_in) begin
      if (reset_in) begin
        scratch_q[i] <= `DBEC_RST_SCRATCH;
      end else if (wr_sel == MY_SEL) begin
        scratch_q[i] <= wr_data[16*(i%2) +: 16];
      end
    end
  end

  // Configuration: debug clock enable and core run enable
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      dbg_en_q <= 1'b0;
      core_en_q <= 1'b0;
    end else if (wr_cfg) begin
      dbg_en_q <= wr_data[`DBEC_BIT_DBG_CLK];
      core_en_q <= wr_data[`DBEC_BIT_CORE_EN];
    end
  end

  // Sticky error flags; the set beats a same-cycle clear
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      lock_q <= 1'b0;
      inval_q <= 1'b0;
    end else begin
      lock_q <= lock_ev || (lock_q && !clear_cmd);
      inval_q <= addr_ev || (inval_q && !clear_cmd);
    end
  end

  // Pause control bit
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pause_q <= 1'b0;
    end else if (wr_lockctl) begin
      pause_q <= wr_data[`DBEC_BIT_PAUSE];
    end
  end

  // Program and data address capture for the first lock error
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pmem_q <= `DBEC_RST_PMEM;
      xmem_q <= `DBEC_RST_XMEM;
    end else if (take_lock) begin
      pmem_q <= dsp_pc_prefetch_in;
      xmem_q <= dsp_xaddr_in;
    end
  end

  // Bus fault address; with both flags clear it keeps whatever it had,
  // which software must not trust
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      buserr_q <= `DBEC_RST_BUSERR;
    end else if (take_lock || take_inval) begin
      buserr_q <= fault_addr;
    end
  end

  // Interrupt status, write one to clear, set wins
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      irq_sts_q <= `DBEC_RST_IRQ;
    end else begin
      irq_sts_q <= irq_set | (irq_sts_q & ~(wr_irqsts ? wr_data[2:0] : 3'h0));
    end
  end

  // Interrupt mask
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      irq_mask_q <= `DBEC_RST_IRQ;
    end else if (wr_irqmask) begin
      irq_mask_q <= wr_data[2:0];
    end
  end

  // Pause state: halt on lock error, resume on pause clear or enable drop
  always_comb begin
    run_d = run_q;
    unique case (run_q)
      dbec_pkg::ST_RUN: begin
        if (lock_ev && pause_q && core_en_q) begin
          run_d = dbec_pkg::ST_HALT;
        end
      end
      dbec_pkg::ST_HALT: begin
        // Enable cleared means the core restarts once set again
        if (!pause_q || !core_en_q) begin
          run_d = dbec_pkg::ST_RUN;
        end
      end
    endcase
  end

  // State register and its registered halt copy
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      run_q <= dbec_pkg::ST_RUN;
      halt_q <= 1'b0;
    end else begin
      run_q <= run_d;
      halt_q <= (run_d == dbec_pkg::ST_HALT);
    end
  end

  // Read data, one cycle after the strobe; window reads only by firmware
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      host_rdata_q <= 32'h0000_0000;
      dsp_rdata_q <= 32'h0000_0000;
    end else begin
      host_rdata_q <= reg_read_in ? read_word(host_sel) : 32'h0000_0000;
      dsp_rdata_q <= (win_hit && !dsp_we_in) ? read_word(win_sel) : 32'h0000_0000;
    end
  end

  // Debug clock pin: two-stage synchroniser, then gate. Sampling limits the
  // passed clock to well under half the block clock.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      jtag_meta_q <= 1'b0;
      jtag_sync_q <= 1'b0;
      jtag_gated_q <= 1'b0;
    end else begin
      jtag_meta_q <= jtag_clock_in;
      jtag_sync_q <= jtag_meta_q;
      jtag_gated_q <= jtag_sync_q && dbg_en_q;
    end
  end

  // Bus error event pulse and level interrupt
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      event_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      event_q <= lock_ev || addr_ev || watchdog_timeout_in;
      irq_q <= |(irq_sts_q & irq_mask_q);
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_out = host_rdata_q;
  assign dsp_rdata_out = dsp_rdata_q;
  assign dsp_halt_out = halt_q;
  assign core_enable_out = core_en_q;
  assign jtag_clock_core_out = jtag_gated_q;
  assign bus_error_event_out = event_q;
  assign irq_out = irq_q;

  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  a_lock_flag_set: assert property (lock_ev |=> lock_q)
    else $error("lock flag not set after locked write");
  a_inval_flag_set: assert property (addr_ev |=> inval_q)
    else $error("address flag not set after invalid access");
  a_clear_both: assert property (clear_cmd && !lock_ev && !addr_ev |=> !lock_q && !inval_q)
    else $error("clear did not drop both flags");
  a_first_lock_held: assert property (lock_q && !clear_cmd |=> $stable(pmem_q) && $stable(xmem_q))
    else $error("lock capture overwritten while flag set");
  a_prefetch_captured: assert property (lock_ev && !lock_q |=> pmem_q == $past(dsp_pc_prefetch_in))
    else $error("program address not the prefetched one");
  a_bus_addr_frozen: assert property (lock_q && !clear_cmd |=> $stable(buserr_q))
    else $error("bus address moved while lock flag set");
  a_bus_tracks_inval: assert property (take_inval |=> buserr_q == $past(fault_addr))
    else $error("bus address missed invalid access");
  a_byte_referenced: assert property (take_lock |=> buserr_q == {$past(dsp_reg_addr_in), 1'b0})
    else $error("bus address not byte-referenced");
  a_window_zero: assert property (win_bad && !lock_ev && !lock_keep |=> buserr_q == 24'h000000)
    else $error("window error not recorded as zero");
  a_halt_on_lock: assert property (lock_ev && pause_q && core_en_q && !halt_q |=> dsp_halt_out)
    else $error("core not halted on lock error");
  a_resume_pause: assert property (dsp_halt_out && !pause_q |=> !dsp_halt_out)
    else $error("core stayed halted after pause cleared");
  a_dbg_clk_gate: assert property (!dbg_en_q |=> !jtag_clock_core_out)
    else $error("debug clock passed while disabled");
  a_event_pulse: assert property (watchdog_timeout_in |=> bus_error_event_out)
    else $error("no bus error event on watchdog");
  a_host_no_window: assert property (reg_read_in && reg_addr_in >= `DBEC_VIRT_FIRST
    && reg_addr_in <= `DBEC_VIRT_LAST |=> reg_rdata_out == 32'h0000_0000)
    else $error("virtual range reachable from host");

  // Restart path, event pulse and interrupt level
  a_resume_enable: assert property (dsp_halt_out && !core_en_q |=> !dsp_halt_out)
    else $error("core stayed halted after enable cleared");
  a_event_lock: assert property (lock_ev || addr_ev |=> bus_error_event_out)
    else $error("no bus error event on core bus error");
  a_event_quiet: assert property (!(lock_ev || addr_ev || watchdog_timeout_in)
    |=> !bus_error_event_out)
    else $error("bus error event without an error");
  a_irq_level: assert property (|(irq_sts_q & irq_mask_q) |=> irq_out)
    else $error("interrupt low with unmasked status set");

  // Plain storage, gated clock and idle read port
  a_scratch_store: assert property (wr_sel == dbec_pkg::SEL_SCR_LO
    |=> {scratch_q[1], scratch_q[0]} == $past(wr_data))
    else $error("scratch word not stored as written");
  a_debug_clk_pass: assert property (dbg_en_q && jtag_sync_q |=> jtag_clock_core_out)
    else $error("debug clock blocked while enabled");
  a_host_rdata_idle: assert property (!reg_read_in |=> reg_rdata_out == 32'h0000_0000)
    else $error("host read data not zero outside read cycle");

  c_lock_capture: cover property (lock_ev ##1 lock_q ##[1:20] clear_cmd);
  c_pause_resume: cover property (dsp_halt_out ##[1:50] !dsp_halt_out);
  c_window_write: cover property (win_wr && win_sel == dbec_pkg::SEL_SCR_HI);
  c_window_miss: cover property (win_bad);
  c_irq_raised: cover property (!irq_out ##1 irq_out);

endmodule

`default_nettype wire

// ==== dbec_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Behavioural core side: data bus master and watchdog source
module dbec_core_model (
  // Clock
  input wire logic clock_in,
  // Core data bus
  output logic req_out,
  output logic we_out,
  output logic [15:0] xaddr_out,
  output logic [31:0] wdata_out,
  output logic [22:0] reg_addr_out,
  output logic [14:0] pc_out,
  output logic locked_out,
  output logic invalid_out,
  // Watchdog error pulse
  output logic watchdog_out
);
  // Idle bus at time zero
  initial begin
    {req_out, we_out, xaddr_out, wdata_out} = '0;
    {reg_addr_out, pc_out, locked_out, invalid_out, watchdog_out} = '0;
  end

  // One access, one cycle wide
  task automatic access(input logic we, input logic [15:0] xa, input logic [31:0] wd,
                        input logic [22:0] ra, input logic [14:0] pc, input logic lk,
                        input logic inv);
    @(posedge clock_in);
    req_out <= 1'b1;
    {we_out, xaddr_out, wdata_out, reg_addr_out} <= {we, xa, wd, ra};
    {pc_out, locked_out, invalid_out} <= {pc, lk, inv};
    @(posedge clock_in);
    req_out <= 1'b0;
    // Released lines except pc_out show inverted leftovers so a stale copy cannot pass
    {we_out, xaddr_out, wdata_out, reg_addr_out} <= ~{we, xa, wd, ra};
    {locked_out, invalid_out} <= ~{lk, inv};
  endtask

  // Single watchdog error pulse
  task automatic bark();
    @(posedge clock_in);
    watchdog_out <= 1'b1;
    @(posedge clock_in);
    watchdog_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== dbec_debug_capture_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dbec_cfg.svh"
`define CHK(g, e) check_val(32'(g), 32'(e))
// Self-checking bench for the debug and bus-error capture block
module dbec_debug_capture_tb;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  // Host port
  logic [19:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic jtag_clk = 1'b0;
  wire logic [31:0] reg_rdata, dsp_rdata;
  wire logic req, we, lk, inv, wdog, halt, core_en, jtag_core, event_p, irq;
  wire logic [15:0] xa;
  wire logic [31:0] wd;
  wire logic [22:0] ra;
  wire logic [14:0] pc;
  logic [31:0] rd;
  int errors = 0;
  int cmp_count = 0;

  // 40 MHz clock
  always #12.5 clock_in = ~clock_in;

  dbec_core_model i_core (.clock_in(clock_in), .req_out(req), .we_out(we), .xaddr_out(xa),
    .wdata_out(wd), .reg_addr_out(ra), .pc_out(pc), .locked_out(lk), .invalid_out(inv),
    .watchdog_out(wdog));

  dbec_debug_capture i_dut (.clock_in(clock_in), .reset_in(reset_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_write_in(reg_write), .reg_read_in(reg_read),
    .reg_rdata_out(reg_rdata), .dsp_req_in(req), .dsp_we_in(we), .dsp_xaddr_in(xa),
    .dsp_wdata_in(wd), .dsp_reg_addr_in(ra), .dsp_pc_prefetch_in(pc), .dsp_locked_in(lk),
    .dsp_invalid_in(inv), .dsp_rdata_out(dsp_rdata), .watchdog_timeout_in(wdog),
    .dsp_halt_out(halt), .core_enable_out(core_en), .jtag_clock_in(jtag_clk),
    .jtag_clock_core_out(jtag_core), .bus_error_event_out(event_p), .irq_out(irq));

  // Compare and count
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Host write, one strobe cycle
  task automatic reg_wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge clock_in);
    {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
    @(posedge clock_in);
    reg_write <= 1'b0;
  endtask

  // Host read, data taken in the cycle after the strobe
  task automatic reg_rd(input logic [19:0] a, output logic [31:0] d);
    @(posedge clock_in);
    {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge clock_in);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Reset values and refused host addresses
  task automatic t_reset_map();
    logic [19:0] map[8];
    map = '{`DBEC_ADDR_CFG, `DBEC_ADDR_SCR_LO, `DBEC_ADDR_SCR_HI, `DBEC_ADDR_BUSERR,
            `DBEC_ADDR_LOCKCTL, `DBEC_ADDR_PXADDR, `DBEC_ADDR_IRQSTS, `DBEC_ADDR_IRQMASK};
    foreach (map[i]) begin
      reg_rd(map[i], rd);
      `CHK(rd, 32'h0000_0000);
    end
    `CHK({halt, irq, event_p, core_en}, 4'h0);
    reg_wr(20'h01040, 32'h1111_2222);
    reg_rd(20'h01040, rd);
    `CHK(rd, 32'h0000_0000);
  endtask

  // Scratch from host and through the core window
  task automatic t_scratch();
    reg_wr(`DBEC_ADDR_SCR_LO, 32'hbeef_1234);
    reg_wr(`DBEC_ADDR_SCR_HI, 32'hffff_0001);
    reg_rd(`DBEC_ADDR_SCR_LO, rd);
    `CHK(rd, 32'hbeef_1234);
    i_core.access(1'b1, `DBEC_WIN_FIRST + 16'h0042, 32'h5a5a_a5a5, 23'h0, 15'h0, 1'b0, 1'b0);
    reg_rd(`DBEC_ADDR_SCR_HI, rd);
    `CHK(rd, 32'h5a5a_a5a5);
    i_core.access(1'b0, `DBEC_WIN_FIRST + 16'h0040, 32'h0, 23'h0, 15'h0, 1'b0, 1'b0);
    #1 `CHK(dsp_rdata, 32'hbeef_1234);
  endtask

  // Debug clock gate, core enable kept set while debugging
  task automatic t_debug_clock();
    @(posedge clock_in);
    jtag_clk <= 1'b1;
    repeat (5) @(posedge clock_in);
    #1 `CHK(jtag_core, 1'b0);
    reg_wr(`DBEC_ADDR_CFG, 32'h0000_0009);
    repeat (5) @(posedge clock_in);
    #1 `CHK({jtag_core, core_en}, 2'h3);
    @(posedge clock_in);
    jtag_clk <= 1'b0;
    repeat (5) @(posedge clock_in);
    #1 `CHK(jtag_core, 1'b0);
  endtask

  // Lock errors, pause, freeze of captures, restart
  task automatic t_lock();
    reg_wr(`DBEC_ADDR_IRQMASK, 32'h0000_0007);
    reg_wr(`DBEC_ADDR_LOCKCTL, 32'h0000_0002);
    i_core.access(1'b1, 16'h0456, 32'h0, 23'h123456, 15'h1abc, 1'b1, 1'b0);
    #1 `CHK({event_p, halt}, 2'h3);
    @(posedge clock_in);
    #1 `CHK({event_p, irq}, 2'h1);
    i_core.access(1'b1, 16'h0999, 32'h0, 23'h00abcd, 15'h0222, 1'b1, 1'b0);
    i_core.access(1'b0, 16'h0100, 32'h0, 23'h000777, 15'h0333, 1'b0, 1'b1);
    reg_rd(`DBEC_ADDR_PXADDR, rd);
    `CHK(rd, {1'b0, 15'h1abc, 16'h0456});
    reg_rd(`DBEC_ADDR_BUSERR, rd);
    `CHK(rd, {8'h00, 23'h123456, 1'b0});
    reg_rd(`DBEC_ADDR_LOCKCTL, rd);
    `CHK(rd, 32'h0000_c002);
    reg_wr(`DBEC_ADDR_LOCKCTL, 32'h0000_0000);
    @(posedge clock_in);
    #1 `CHK(halt, 1'b0);
    reg_wr(`DBEC_ADDR_LOCKCTL, 32'h0000_0003);
    reg_rd(`DBEC_ADDR_LOCKCTL, rd);
    `CHK(rd, 32'h0000_0002);
    i_core.access(1'b1, 16'h0abc, 32'h0, 23'h000042, 15'h7fff, 1'b1, 1'b0);
    #1 `CHK(halt, 1'b1);
    reg_rd(`DBEC_ADDR_PXADDR, rd);
    `CHK(rd, {1'b0, 15'h7fff, 16'h0abc});
    reg_wr(`DBEC_ADDR_CFG, 32'h0000_0008);
    @(posedge clock_in);
    #1 `CHK({halt, core_en}, 2'h0);
    reg_wr(`DBEC_ADDR_CFG, 32'h0000_0009);
    reg_wr(`DBEC_ADDR_LOCKCTL, 32'h0000_0001);
    i_core.access(1'b1, 16'h0001, 32'h0, 23'h000001, 15'h0001, 1'b1, 1'b0);
    #1 `CHK({event_p, halt}, 2'h2);
    reg_wr(`DBEC_ADDR_LOCKCTL, 32'h0000_0001);
    reg_wr(`DBEC_ADDR_IRQSTS, 32'h0000_0007);
    @(posedge clock_in);
    #1 `CHK(irq, 1'b0);
  endtask

  // Invalid accesses, tracking, window miss, mask, watchdog
  task automatic t_invalid();
    reg_wr(`DBEC_ADDR_IRQMASK, 32'h0000_0000);
    i_core.access(1'b0, 16'h0200, 32'h0, 23'h000100, 15'h0, 1'b0, 1'b1);
    reg_rd(`DBEC_ADDR_BUSERR, rd);
    `CHK(rd, 32'h0000_0200);
    i_core.access(1'b1, 16'h0300, 32'h0, 23'h7ffff0, 15'h0, 1'b0, 1'b1);
    reg_rd(`DBEC_ADDR_BUSERR, rd);
    `CHK(rd, 32'h00ff_ffe0);
    reg_rd(`DBEC_ADDR_LOCKCTL, rd);
    `CHK(rd, 32'h0000_4000);
    `CHK(irq, 1'b0);
    reg_wr(`DBEC_ADDR_IRQMASK, 32'h0000_0002);
    @(posedge clock_in);
    #1 `CHK(irq, 1'b1);
    i_core.access(1'b0, `DBEC_WIN_FIRST + 16'h0010, 32'h0, 23'h055555, 15'h0, 1'b0, 1'b0);
    reg_rd(`DBEC_ADDR_BUSERR, rd);
    `CHK(rd, 32'h0000_0000);
    i_core.bark();
    #1 `CHK(event_p, 1'b1);
    reg_rd(`DBEC_ADDR_IRQSTS, rd);
    `CHK(rd, 32'h0000_0006);
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clock_in);
    reset_in <= 1'b0;
    t_reset_map();
    t_scratch();
    t_debug_clock();
    t_lock();
    t_invalid();
    wrap_up();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clock_in);
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
